/* thc_defs.svh */
// Constants for the two-hand control monitor: offsets, fields, timing
// =====================================================================
`ifndef THC_DEFS_SVH
`define THC_DEFS_SVH

// =====================================================================
// Register offsets (byte addresses)
`define THC_ADDR_W 8
`define THC_OFF_CTRL 8'h00
`define THC_OFF_STATUS 8'h04
`define THC_OFF_DIAG 8'h08
`define THC_OFF_IRQ_STAT 8'h0c
`define THC_OFF_IRQ_MASK 8'h10

// =====================================================================
// Field positions
`define THC_CTRL_ACTIVATE 0
`define THC_IRQ_GRANT 0
`define THC_IRQ_ERROR 1
`define THC_IRQ_DROP 2
`define THC_IRQ_W 3

// =====================================================================
// Reset values
`define THC_DIAG_RESET 16'h0000
`define THC_IRQ_MASK_RESET 3'h0

// =====================================================================
// Diagnostic codes
`define THC_D_IDLE 16'h0000
`define THC_D_ACTUATED 16'h8000
`define THC_D_INIT 16'h8001
`define THC_D_RELEASED 16'h8802
`define THC_D_ONLY_B1 16'h8804
`define THC_D_ONLY_B2 16'h8806
`define THC_D_B2_REL 16'h8808
`define THC_D_B1_REL 16'h880a
`define THC_D_LOCK_OFF 16'h880c
`define THC_D_LOCK_ON 16'h880e
`define THC_D_ACT_B1 16'hc010
`define THC_D_ACT_B2 16'hc020
`define THC_D_ACT_BOTH 16'hc030
`define THC_D_TMO_B2 16'hc040
`define THC_D_TMO_B1 16'hc050
`define THC_D_TMO_BOTH 16'hc060

// =====================================================================
// Timing
`define THC_CLK_HZ 40000000
`define THC_DISCREP_MS 500
`define THC_TIMER_W 25
`define THC_DISCREP_CYCLES (`THC_DISCREP_MS * (`THC_CLK_HZ / 1000))

`endif

/* thc_pkg.sv */
// Types shared by the two-hand control monitor
`include "thc_defs.svh"

package thc_pkg;

  // =====================================================================
  // Monitor states
  typedef enum logic [3:0]
  {
    ST_IDLE,
    ST_INIT,
    ST_RELEASED,
    ST_ONLY_B1,
    ST_ONLY_B2,
    ST_ACTUATED,
    ST_B2_REL,
    ST_B1_REL,
    ST_LOCK_OFF,
    ST_LOCK_ON,
    ST_ERROR
  } state_t;

  // =====================================================================
  // Whole state of the monitor
  typedef struct packed
  {
    state_t state;                        // Monitor state
    logic [15:0] err_code;                // Code latched on error entry
    logic [`THC_TIMER_W-1:0] timer;       // Discrepancy timer
    logic activate;                       // Software activate bit
    logic [`THC_IRQ_W-1:0] irq_stat;      // Sticky events
    logic [`THC_IRQ_W-1:0] irq_mask;      // Event enables
    logic [31:0] prdata;                  // Bus read data
    logic pready;                         // Bus ready
    logic pslverr;                        // Bus error
    logic irq;                            // Interrupt line
    logic enable;                         // Two-hand enable
    logic ready;                          // Block active
    logic error;                          // Error present
    logic safety_req;                     // Safety request
    logic [15:0] diag;                    // Diagnostic word
  } mon_t;

  // =====================================================================
  // Synchroniser state
  typedef struct packed
  {
    logic [2:0] chain;                    // Three-stage chain
    logic level;                          // Agreed level
  } sync_t;

endpackage

/* input_sync.sv */
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none

module input_sync
(
  input wire logic clk,
  input wire logic rst,
  input wire logic din,
  output logic dout
);

  thc_pkg::sync_t r; // Registered state
  thc_pkg::sync_t n; // Next state

  // =====================================================================
  // Next state: stage one feeds only stage two
  always_comb
  begin
    n = r;
    n.chain = {r.chain[1:0], din};
    // Level changes only once stages two and three agree
    if (r.chain[1] == r.chain[2])
    begin
      n.level = r.chain[2];
    end
  end

  // =====================================================================
  // Registers: buttons read released under reset
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      r <= '0;
    end
    else
    begin
      r <= n;
    end
  end

  assign dout = r.level;

endmodule

`default_nettype wire

/* bimanual_control_block.sv */
// Two-hand control monitor with APB registers and interrupt
`timescale 1ns/1ps
`default_nettype none
// Offsets, fields, codes and timing counts; guarded, so a second
// inclusion through the package is harmless
`include "thc_defs.svh"

module bimanual_control_block
#(
  // Discrepancy window in cycles; shorten for simulation
  parameter int unsigned DISCREP_CYCLES = `THC_DISCREP_CYCLES
)
(
  input wire logic CLK_SYS,
  input wire logic RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [`THC_ADDR_W-1:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic FIRST_BUTTON_INPUT,
  input wire logic SECOND_BUTTON_INPUT,
  output logic BIMANUAL_ENABLE_OUTPUT,
  output logic READY,
  output logic ERROR,
  output logic SAFETY_REQUEST_FLAG,
  output logic [15:0] DIAGNOSTIC_WORD,
  output logic IRQ
);

  // =====================================================================
  // Constants and declarations

  // Last count of the window, cut to timer width
  localparam logic [`THC_TIMER_W-1:0] TIMER_LAST =
    `THC_TIMER_W'(DISCREP_CYCLES - 1);

  thc_pkg::mon_t r; // Registered state
  thc_pkg::mon_t n; // Next state
  logic b1; // Filtered first button
  logic b2; // Filtered second button
  logic setup; // Bus setup cycle
  logic done; // Bus transfer completes this edge
  logic mapped; // Address hits a register
  logic elapsed; // Discrepancy window used up

  // =====================================================================
  // Functions

  // Diagnostic word for a state; errors use the latched code
  function automatic logic [15:0] diag_of
  (
    input thc_pkg::state_t s,
    input logic [15:0] code
  );
    logic [15:0] d;
    d = `THC_D_IDLE;
    unique case (s)
      thc_pkg::ST_IDLE: d = `THC_D_IDLE;
      thc_pkg::ST_INIT: d = `THC_D_INIT;
      thc_pkg::ST_RELEASED: d = `THC_D_RELEASED;
      thc_pkg::ST_ONLY_B1: d = `THC_D_ONLY_B1;
      thc_pkg::ST_ONLY_B2: d = `THC_D_ONLY_B2;
      thc_pkg::ST_ACTUATED: d = `THC_D_ACTUATED;
      thc_pkg::ST_B2_REL: d = `THC_D_B2_REL;
      thc_pkg::ST_B1_REL: d = `THC_D_B1_REL;
      thc_pkg::ST_LOCK_OFF: d = `THC_D_LOCK_OFF;
      thc_pkg::ST_LOCK_ON: d = `THC_D_LOCK_ON;
      thc_pkg::ST_ERROR: d = code;
      default: d = `THC_D_IDLE;
    endcase
    return d;
  endfunction

  // Address decode, shared by write gate and error answer
  function automatic logic is_mapped
  (
    input logic [`THC_ADDR_W-1:0] a
  );
    return (a == `THC_OFF_CTRL) || (a == `THC_OFF_STATUS) ||
      (a == `THC_OFF_DIAG) || (a == `THC_OFF_IRQ_STAT) ||
      (a == `THC_OFF_IRQ_MASK);
  endfunction

  // =====================================================================
  // Button synchronisers

  // Buttons are pins from outside the clock domain
  input_sync u_sync_b1
  (
    .clk(CLK_SYS),
    .rst(RST),
    .din(FIRST_BUTTON_INPUT),
    .dout(b1)
  );

  input_sync u_sync_b2
  (
    .clk(CLK_SYS),
    .rst(RST),
    .din(SECOND_BUTTON_INPUT),
    .dout(b2)
  );

  // =====================================================================
  // Next-state logic
  always_comb
  begin
    n = r;
    setup = PSEL && !PENABLE;
    done = PSEL && PENABLE && r.pready;
    mapped = is_mapped(PADDR);
    elapsed = (r.timer >= TIMER_LAST);

    // Bus: ready rises one cycle after setup, for one cycle only
    n.pready = setup;
    if (setup)
    begin
      n.pslverr = !mapped;
      n.prdata = '0;
      // Read data is captured in setup and held through access
      unique case (PADDR)
        `THC_OFF_CTRL:
          n.prdata[`THC_CTRL_ACTIVATE] = r.activate;
        `THC_OFF_STATUS:
          n.prdata[5:0] = {b2, b1, r.safety_req, r.error,
            r.ready, r.enable};
        `THC_OFF_DIAG:
          n.prdata[15:0] = r.diag;
        `THC_OFF_IRQ_STAT:
          n.prdata[`THC_IRQ_W-1:0] = r.irq_stat;
        `THC_OFF_IRQ_MASK:
          n.prdata[`THC_IRQ_W-1:0] = r.irq_mask;
        default:
          n.prdata = '0;
      endcase
    end
    else if (done)
    begin
      // Hold error through the completing edge only; data stays until next setup
      n.pslverr = 1'b0;
    end

    // Writes take effect at the completing edge
    if (done && PWRITE && mapped)
    begin
      if (PADDR == `THC_OFF_CTRL)
      begin
        n.activate = PWDATA[`THC_CTRL_ACTIVATE];
      end
      if (PADDR == `THC_OFF_IRQ_MASK)
      begin
        n.irq_mask = PWDATA[`THC_IRQ_W-1:0];
      end
    end

    // Read of the event register clears only the bits it returned;
    // an event landing on the setup edge missed the read data and
    // must survive to the next read. Events below still win.
    if (done && !PWRITE && (PADDR == `THC_OFF_IRQ_STAT))
    begin
      n.irq_stat = r.irq_stat & ~r.prdata[`THC_IRQ_W-1:0];
    end

    // Discrepancy timer runs only in single-button states
    n.timer = '0;

    // Monitor state machine
    if (!r.activate)
    begin
      // Leaving activation beats every other move
      n.state = thc_pkg::ST_IDLE;
    end
    else
    begin
      unique case (r.state)
        thc_pkg::ST_IDLE:
          n.state = thc_pkg::ST_INIT;
        thc_pkg::ST_INIT:
        begin
          // Any button held at activation is refused
          if (b1 || b2)
          begin
            n.state = thc_pkg::ST_ERROR;
            n.err_code = (b1 && b2) ? `THC_D_ACT_BOTH :
              (b1 ? `THC_D_ACT_B1 : `THC_D_ACT_B2);
          end
          else
          begin
            n.state = thc_pkg::ST_RELEASED;
          end
        end
        thc_pkg::ST_RELEASED:
        begin
          // Press in the same cycle counts as within the window
          if (b1 && b2)
          begin
            n.state = thc_pkg::ST_ACTUATED;
          end
          else if (b1)
          begin
            n.state = thc_pkg::ST_ONLY_B1;
          end
          else if (b2)
          begin
            n.state = thc_pkg::ST_ONLY_B2;
          end
        end
        thc_pkg::ST_ONLY_B1,
        thc_pkg::ST_ONLY_B2:
        begin
          n.timer = r.timer + `THC_TIMER_W'(1);
          if (elapsed)
          begin
            // Window over: inputs at this cycle choose the code
            n.state = thc_pkg::ST_ERROR;
            n.err_code = (b1 && b2) ? `THC_D_TMO_BOTH :
              (b1 ? `THC_D_TMO_B1 : `THC_D_TMO_B2);
          end
          else if (b1 && b2)
          begin
            n.state = thc_pkg::ST_ACTUATED;
          end
          else if (!b1 && !b2)
          begin
            n.state = thc_pkg::ST_RELEASED;
          end
          else if ((r.state == thc_pkg::ST_ONLY_B1) ? b2 : b1)
          begin
            // Buttons swapped in one cycle: wait for full release
            n.state = thc_pkg::ST_LOCK_ON;
          end
        end
        thc_pkg::ST_ACTUATED:
        begin
          // Either release drops enable; a full release is needed
          if (!b1 && !b2)
          begin
            n.state = thc_pkg::ST_RELEASED;
          end
          else if (b1 && !b2)
          begin
            n.state = thc_pkg::ST_B2_REL;
          end
          else if (!b1 && b2)
          begin
            n.state = thc_pkg::ST_B1_REL;
          end
        end
        thc_pkg::ST_B2_REL,
        thc_pkg::ST_B1_REL,
        thc_pkg::ST_LOCK_OFF,
        thc_pkg::ST_LOCK_ON:
        begin
          // Re-pressing does not re-enable; only full release does
          if (!b1 && !b2)
          begin
            n.state = thc_pkg::ST_RELEASED;
          end
          else if (b1 && b2 && (r.state != thc_pkg::ST_LOCK_ON))
          begin
            n.state = thc_pkg::ST_LOCK_OFF;
          end
          else if (r.state != thc_pkg::ST_LOCK_ON)
          begin
            n.state = b1 ? thc_pkg::ST_B2_REL : thc_pkg::ST_B1_REL;
          end
        end
        thc_pkg::ST_ERROR:
        begin
          // Error held until both buttons are released
          if (!b1 && !b2)
          begin
            n.state = thc_pkg::ST_RELEASED;
          end
        end
        default:
          n.state = thc_pkg::ST_IDLE;
      endcase
    end

    // Outputs follow the next state so they leave flip-flops
    n.enable = (n.state == thc_pkg::ST_ACTUATED);
    n.ready = (n.state != thc_pkg::ST_IDLE);
    n.error = (n.state == thc_pkg::ST_ERROR);
    // Request while waiting on the operator; omittable output
    n.safety_req = n.ready && !n.enable && !n.error &&
      (n.state != thc_pkg::ST_INIT);
    n.diag = diag_of(n.state, n.err_code);

    // Sticky events: grant, error entry, enable dropped
    if (n.enable && !r.enable)
    begin
      n.irq_stat[`THC_IRQ_GRANT] = 1'b1;
    end
    if (n.error && !r.error)
    begin
      n.irq_stat[`THC_IRQ_ERROR] = 1'b1;
    end
    if (!n.enable && r.enable)
    begin
      n.irq_stat[`THC_IRQ_DROP] = 1'b1;
    end
    n.irq = |(n.irq_stat & n.irq_mask);
  end

  // =====================================================================
  // State register
  // Reset puts the monitor idle with everything false; the
  // function itself has no reset, only the hardware does
  always_ff @(posedge CLK_SYS or posedge RST)
  begin
    if (RST)
    begin
      r <= '0;
      r.state <= thc_pkg::ST_IDLE;
      r.diag <= `THC_DIAG_RESET;
      r.irq_mask <= `THC_IRQ_MASK_RESET;
    end
    else
    begin
      r <= n;
    end
  end

  // =====================================================================
  // Outputs straight from the state register
  assign PRDATA = r.prdata;
  assign PREADY = r.pready;
  assign PSLVERR = r.pslverr;
  assign BIMANUAL_ENABLE_OUTPUT = r.enable;
  assign READY = r.ready;
  assign ERROR = r.error;
  assign SAFETY_REQUEST_FLAG = r.safety_req;
  assign DIAGNOSTIC_WORD = r.diag;
  assign IRQ = r.irq;

endmodule

`default_nettype wire

/* bimanual_control_block_asserts.sv */
// Checker for the two-hand control monitor outputs
`timescale 1ns/1ps
`default_nettype none

module thc_checker
#(
  parameter int unsigned DISCREP_CYCLES = 20
)
(
  input wire logic CLK_SYS,
  input wire logic RST,
  input wire logic BIMANUAL_ENABLE_OUTPUT,
  input wire logic READY,
  input wire logic ERROR,
  input wire logic SAFETY_REQUEST_FLAG,
  input wire logic [15:0] DIAGNOSTIC_WORD
);
  // =====================================================================
  // Clocking
  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (RST);

  // Consecutive cycles in a one-hand state; one cycle of slack for the
  // registered timer compare
  int unsigned single_cnt;

  // Count while one hand waits for the other
  always_ff @(posedge CLK_SYS or posedge RST)
  begin
    if (RST)
      single_cnt <= 0;
    else if (DIAGNOSTIC_WORD inside {16'h8804, 16'h8806})
      single_cnt <= single_cnt + 1;
    else
      single_cnt <= 0;
  end

  // =====================================================================
  // Properties
  a_enable_state: assert property (
    BIMANUAL_ENABLE_OUTPUT |-> DIAGNOSTIC_WORD == 16'h8000 && READY && !ERROR)
    else $error("enable outside actuated state");
  a_enable_entry: assert property (
    $rose(BIMANUAL_ENABLE_OUTPUT)
    |-> $past(DIAGNOSTIC_WORD) inside {16'h8802, 16'h8804, 16'h8806})
    else $error("enable from wrong state");
  a_idle_quiet: assert property (
    !READY |-> DIAGNOSTIC_WORD == 16'h0000 && !BIMANUAL_ENABLE_OUTPUT
    && !ERROR && !SAFETY_REQUEST_FLAG)
    else $error("idle outputs not quiet");
  a_error_safe: assert property (
    ERROR |-> READY && !BIMANUAL_ENABLE_OUTPUT && !SAFETY_REQUEST_FLAG)
    else $error("error outputs wrong");
  a_error_code: assert property (
    $rose(ERROR) |-> DIAGNOSTIC_WORD inside {16'hc010, 16'hc020, 16'hc030,
    16'hc040, 16'hc050, 16'hc060})
    else $error("error code unknown");
  a_act_error: assert property (
    $rose(ERROR) && DIAGNOSTIC_WORD inside {16'hc010, 16'hc020, 16'hc030}
    |-> $past(DIAGNOSTIC_WORD) == 16'h8001)
    else $error("activation error not from init");
  a_tmo_error: assert property (
    $rose(ERROR) && DIAGNOSTIC_WORD inside {16'hc040, 16'hc050, 16'hc060}
    |-> $past(DIAGNOSTIC_WORD) inside {16'h8804, 16'h8806})
    else $error("timeout not from one-hand state");
  a_error_hold: assert property (
    ERROR && $past(ERROR) |-> $stable(DIAGNOSTIC_WORD))
    else $error("error code changed");
  a_error_exit: assert property (
    $fell(ERROR) && READY |-> DIAGNOSTIC_WORD == 16'h8802)
    else $error("error left to wrong state");
  a_init_exit: assert property (
    DIAGNOSTIC_WORD == 16'h8001 |=> DIAGNOSTIC_WORD inside {16'h8802,
    16'hc010, 16'hc020, 16'hc030, 16'h0000})
    else $error("init left wrongly");
  a_single_bound: assert property (
    single_cnt <= DISCREP_CYCLES + 1)
    else $error("one-hand state outlasts window");

  // Main scenarios reached
  c_grant: cover property ($rose(BIMANUAL_ENABLE_OUTPUT));
  c_tmo: cover property (DIAGNOSTIC_WORD == 16'hc040);
  c_act: cover property (DIAGNOSTIC_WORD == 16'hc030);
endmodule

bind bimanual_control_block thc_checker
  #(.DISCREP_CYCLES(DISCREP_CYCLES)) u_thc_checker (.CLK_SYS(CLK_SYS),
  .RST(RST), .BIMANUAL_ENABLE_OUTPUT(BIMANUAL_ENABLE_OUTPUT),
  .READY(READY), .ERROR(ERROR), .SAFETY_REQUEST_FLAG(SAFETY_REQUEST_FLAG),
  .DIAGNOSTIC_WORD(DIAGNOSTIC_WORD));
`default_nettype wire

/* button_pair.sv */
// Model of the two operator pushbuttons wired to the monitor
`timescale 1ns/1ps
`default_nettype none

module button_pair
(
  input wire logic clk,
  input wire logic rst,
  input wire logic want1,
  input wire logic want2,
  input wire logic slow,
  output logic btn1,
  output logic btn2
);
  // =====================================================================
  // Contact travel: prompt hands land next edge, slow ones two later
  logic [2:0] sr1;
  logic [2:0] sr2;

  // Hands start off the buttons
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      sr1 <= 3'h0;
      sr2 <= 3'h0;
    end
    else
    begin
      sr1 <= {sr1[1:0], want1};
      sr2 <= {sr2[1:0], want2};
    end
  end

  // Released reads low, actuated reads high
  assign btn1 = slow ? sr1[2] : sr1[0];
  assign btn2 = slow ? sr2[2] : sr2[0];
endmodule
`default_nettype wire

/* tb_bimanual_control_block.sv */
// Self-checking bench for the two-hand control monitor
`timescale 1ns/1ps
`default_nettype none
`include "thc_defs.svh"

module tb_bimanual_control_block;
  // =====================================================================
  // Nets
  logic CLK_SYS, RST, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, IRQ;
  logic [7:0] PADDR;
  logic [31:0] PWDATA, PRDATA, rd;
  logic BIMANUAL_ENABLE_OUTPUT, READY, ERROR, SAFETY_REQUEST_FLAG;
  logic FIRST_BUTTON_INPUT, SECOND_BUTTON_INPUT;
  logic [15:0] DIAGNOSTIC_WORD;
  logic want1, want2, slow, se;
  logic [3:0] flags; // Ready, error, enable and request outputs
  assign flags = {READY, ERROR, BIMANUAL_ENABLE_OUTPUT, SAFETY_REQUEST_FLAG};
  int err_total, n_tests, i;
  // Activation error codes by button pattern (bit0 first, bit1 second)
  logic [15:0] act_code [1:3] = '{16'hc010, 16'hc020, 16'hc030};

  // Short window keeps the timeout cases brief
  bimanual_control_block #(.DISCREP_CYCLES(20)) u_bimanual_control_block (
    .CLK_SYS(CLK_SYS), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
    .PREADY(PREADY), .PSLVERR(PSLVERR),
    .FIRST_BUTTON_INPUT(FIRST_BUTTON_INPUT),
    .SECOND_BUTTON_INPUT(SECOND_BUTTON_INPUT),
    .BIMANUAL_ENABLE_OUTPUT(BIMANUAL_ENABLE_OUTPUT), .READY(READY),
    .ERROR(ERROR), .SAFETY_REQUEST_FLAG(SAFETY_REQUEST_FLAG),
    .DIAGNOSTIC_WORD(DIAGNOSTIC_WORD), .IRQ(IRQ));

  button_pair u_button_pair (.clk(CLK_SYS), .rst(RST), .want1(want1),
    .want2(want2), .slow(slow), .btn1(FIRST_BUTTON_INPUT),
    .btn2(SECOND_BUTTON_INPUT));

  // =====================================================================
  // Clock at 40 MHz
  initial
  begin
    CLK_SYS = 1'b0;
    forever #12.5 CLK_SYS = ~CLK_SYS;
  end

  // Compare and count
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      err_total++;
      $display("mismatch at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask

  // One APB transfer; request held until PREADY is seen at an edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge CLK_SYS);
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLK_SYS);
    PENABLE <= 1'b1;
    // No cycle count assumed; only the watchdog ends a stuck wait
    do
    begin
      @(posedge CLK_SYS);
    end
    while (PREADY !== 1'b1);
    rd = PRDATA;
    se = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask

  // Bounded wait for a diagnostic code, then compare it
  task automatic wait_diag(input logic [15:0] code);
    int n;
    for (n = 0; n < 80 && DIAGNOSTIC_WORD !== code; n++)
      @(posedge CLK_SYS);
    chk({16'h0, DIAGNOSTIC_WORD}, {16'h0, code});
  endtask

  task automatic press(input logic b1, input logic b2);
    @(posedge CLK_SYS);
    want1 <= b1;
    want2 <= b2;
  endtask

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // Hang guard, far beyond the few hundred cycles the run needs
  initial
  begin
    repeat (20000) @(posedge CLK_SYS);
    err_total++;
    tally_and_finish();
  end

  // =====================================================================
  // Main sequence
  initial
  begin
    RST = 1'b1;
    {PSEL, PENABLE, PWRITE, want1, want2, slow} = 6'h0;
    PADDR = 8'h00;
    PWDATA = 32'h0;
    err_total = 0;
    n_tests = 0;
    repeat (3) @(posedge CLK_SYS);
    RST <= 1'b0;
    repeat (2) @(posedge CLK_SYS);
    chk(flags, 4'h0);
    chk(DIAGNOSTIC_WORD, 16'h0000);
    rd_chk(`THC_OFF_IRQ_MASK, 32'h0);
    rd_chk(`THC_OFF_CTRL, 32'h0);
    // Unmapped address: error flag and zero data, both looked at
    apb(1'b0, 8'h14, 32'h0);
    chk({31'h0, se}, 32'h1);
    chk(rd, 32'h0);
    apb(1'b1, `THC_OFF_IRQ_MASK, 32'h7);
    apb(1'b1, `THC_OFF_CTRL, 32'h1);
    wait_diag(16'h8802);
    chk(SAFETY_REQUEST_FLAG, 1'b1);
    // Correct order, second hand slow
    press(1'b1, 1'b0);
    wait_diag(16'h8804);
    slow <= 1'b1;
    press(1'b1, 1'b1);
    wait_diag(16'h8000);
    chk(BIMANUAL_ENABLE_OUTPUT, 1'b1);
    rd_chk(`THC_OFF_STATUS, 32'h33);
    rd_chk(`THC_OFF_DIAG, 32'h8000);
    chk(IRQ, 1'b1);
    rd_chk(`THC_OFF_IRQ_STAT, 32'h1);
    repeat (2) @(posedge CLK_SYS);
    chk(IRQ, 1'b0);
    // Re-arming needs both hands off
    press(1'b0, 1'b1);
    wait_diag(16'h880a);
    press(1'b1, 1'b1);
    wait_diag(16'h880c);
    chk(BIMANUAL_ENABLE_OUTPUT, 1'b0);
    press(1'b0, 1'b0);
    wait_diag(16'h8802);
    rd_chk(`THC_OFF_IRQ_STAT, 32'h4);
    apb(1'b1, `THC_OFF_IRQ_MASK, 32'h0);
    // One hand too long: error held while pressed, masked interrupt
    for (i = 1; i < 3; i++)
    begin
      press(i[0], i[1]);
      wait_diag(i == 1 ? 16'hc050 : 16'hc040);
      repeat (30) @(posedge CLK_SYS);
      chk({ERROR, BIMANUAL_ENABLE_OUTPUT, IRQ}, 3'h4);
      chk(DIAGNOSTIC_WORD, i == 1 ? 16'hc050 : 16'hc040);
      press(1'b0, 1'b0);
      wait_diag(16'h8802);
    end
    apb(1'b1, `THC_OFF_IRQ_MASK, 32'h2);
    repeat (2) @(posedge CLK_SYS);
    chk(IRQ, 1'b1);
    rd_chk(`THC_OFF_IRQ_STAT, 32'h2);
    // Swap of hands
    press(1'b1, 1'b0);
    wait_diag(16'h8804);
    press(1'b0, 1'b1);
    wait_diag(16'h880e);
    press(1'b0, 1'b0);
    wait_diag(16'h8802);
    // Deactivate while enabled
    press(1'b1, 1'b1);
    wait_diag(16'h8000);
    apb(1'b1, `THC_OFF_CTRL, 32'h0);
    wait_diag(16'h0000);
    chk({READY, BIMANUAL_ENABLE_OUTPUT}, 2'b00);
    // Buttons held at activation
    for (i = 1; i < 4; i++)
    begin
      press(i[0], i[1]);
      repeat (8) @(posedge CLK_SYS);
      apb(1'b1, `THC_OFF_CTRL, 32'h1);
      wait_diag(act_code[i]);
      chk(flags, 4'hc);
      press(1'b0, 1'b0);
      wait_diag(16'h8802);
      apb(1'b1, `THC_OFF_CTRL, 32'h0);
      wait_diag(16'h0000);
    end
    tally_and_finish();
  end
endmodule
`default_nettype wire
